//--- smei_defs.svh
// offsets, field positions and reset values of the spi master event/irq bank
`ifndef SMEI_DEFS_SVH
`define SMEI_DEFS_SVH

`define SMEI_ADDR_W         12
`define SMEI_EV_N           5

`define SMEI_OFS_TASK_START 12'h010
`define SMEI_OFS_EV_STOP    12'h104
`define SMEI_OFS_EV_RXDONE  12'h110
`define SMEI_OFS_EV_END     12'h118
`define SMEI_OFS_EV_TXDONE  12'h120
`define SMEI_OFS_EV_BEGAN   12'h14C
`define SMEI_OFS_LINKS      12'h200
`define SMEI_OFS_IEN_SET    12'h304
`define SMEI_OFS_IEN_CLR    12'h308
`define SMEI_OFS_IRQ_STAT   12'h400

`define SMEI_BIT_STOP       0
`define SMEI_BIT_RXDONE     1
`define SMEI_BIT_END        2
`define SMEI_BIT_TXDONE     3
`define SMEI_BIT_BEGAN      4
`define SMEI_BIT_END_START  0
`define SMEI_BIT_TRIGGER    0

`define SMEI_RST_WORD       32'h0000_0000
`define SMEI_RST_EV         5'h00
`define SMEI_RST_LINK       1'b0

`endif

//--- smei_event_flag.sv
// one event flag: hardware sets, software writes
module smei_event_flag
  import smei_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic hw_set,
  input  wire logic sw_wr,
  input  wire logic sw_val,
  output logic      flag_ff
);

  // set wins so an event in the clearing cycle is kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_ff <= 1'b0;
    end else if (hw_set) begin
      flag_ff <= 1'b1;
    end else if (sw_wr) begin
      flag_ff <= sw_val;
    end
  end

  property p_set_wins;
    @(posedge clk) disable iff (rst) hw_set |=> flag_ff;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost on set");

  property p_sw_write;
    @(posedge clk) disable iff (rst) (sw_wr && !hw_set) |=> (flag_ff == $past(sw_val));
  endproperty
  a_sw_write: assert property (p_sw_write) else $error("flag write not taken");

endmodule // smei_event_flag

//--- smei_pkg.sv
// types of the spi master event/irq bank
package smei_pkg;
  typedef logic [11:0] smei_addr_type;
  typedef logic [31:0] smei_word_type;
  typedef logic [4:0]  smei_evset_type;
  // which buffer completions are still outstanding in the current transfer
  typedef enum logic [1:0] {XF_IDLE, XF_BOTH, XF_RX, XF_TX} smei_xfer_type;
endpackage : smei_pkg

//--- smei_regs.sv
// event flags, restart link and interrupt enables of the spi master unit
`include "smei_defs.svh"

module smei_regs
  import smei_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst,
  input  smei_addr_type addr,
  input  smei_word_type wdata,
  input  wire logic    wr_en,
  input  wire logic    rd_en,
  output smei_word_type rdata,
  input  wire logic    ev_stopped,
  input  wire logic    ev_rx_done,
  input  wire logic    ev_tx_done,
  input  wire logic    ev_started,
  output logic         start_task,
  output logic         irq
);

  smei_evset_type ev_hit;
  smei_evset_type ev_wr;
  smei_evset_type flags;
  smei_evset_type ien_ff;
  smei_evset_type nxt_ien;
  smei_evset_type stat_ff;
  smei_evset_type nxt_stat;
  smei_xfer_type  xfer_ff;
  smei_xfer_type  nxt_xfer;
  smei_word_type  rdata_ff;
  smei_word_type  nxt_rdata;
  logic           end_hit;
  logic           links_ff;
  logic           start_task_ff;
  logic           irq_ff;
  logic           start_wr;

  assign rdata      = rdata_ff;
  assign start_task = start_task_ff;
  assign irq        = irq_ff;

  // combined done tracking
  always_comb begin
    nxt_xfer = xfer_ff;
    end_hit  = 1'b0;
    unique case (xfer_ff)
      XF_IDLE: begin
        nxt_xfer = XF_IDLE;
      end
      XF_BOTH: begin
        if (ev_rx_done && ev_tx_done) begin
          end_hit  = 1'b1;
          nxt_xfer = XF_IDLE;
        end else if (ev_rx_done) begin
          nxt_xfer = XF_TX;
        end else if (ev_tx_done) begin
          nxt_xfer = XF_RX;
        end
      end
      XF_RX: begin
        if (ev_rx_done) begin
          end_hit  = 1'b1;
          nxt_xfer = XF_IDLE;
        end
      end
      XF_TX: begin
        if (ev_tx_done) begin
          end_hit  = 1'b1;
          nxt_xfer = XF_IDLE;
        end
      end
    endcase
    // a new transfer restarts the bookkeeping
    if (ev_started) begin
      nxt_xfer = XF_BOTH;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xfer_ff <= XF_IDLE;
    end else begin
      xfer_ff <= nxt_xfer;
    end
  end

  always_comb begin
    ev_hit                  = '0;
    ev_hit[`SMEI_BIT_STOP]   = ev_stopped;
    ev_hit[`SMEI_BIT_RXDONE] = ev_rx_done;
    ev_hit[`SMEI_BIT_END]    = end_hit;
    ev_hit[`SMEI_BIT_TXDONE] = ev_tx_done;
    ev_hit[`SMEI_BIT_BEGAN]  = ev_started;
  end

  always_comb begin
    ev_wr = '0;
    if (wr_en) begin
      unique case (addr)
        `SMEI_OFS_EV_STOP:   ev_wr[`SMEI_BIT_STOP]   = 1'b1;
        `SMEI_OFS_EV_RXDONE: ev_wr[`SMEI_BIT_RXDONE] = 1'b1;
        `SMEI_OFS_EV_END:    ev_wr[`SMEI_BIT_END]    = 1'b1;
        `SMEI_OFS_EV_TXDONE: ev_wr[`SMEI_BIT_TXDONE] = 1'b1;
        `SMEI_OFS_EV_BEGAN:  ev_wr[`SMEI_BIT_BEGAN]  = 1'b1;
        default:             ev_wr = '0;
      endcase
    end
  end

  // one flag per event; are five of these
  for (genvar gi = 0; gi < `SMEI_EV_N; gi++) begin : g_flag
    smei_event_flag u_flag (
      .clk     (clk),
      .rst     (rst),
      .hw_set  (ev_hit[gi]),
      .sw_wr   (ev_wr[gi]),
      .sw_val  (wdata[0]),
      .flag_ff (flags[gi])
    );
  end

  // restart link
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      links_ff <= `SMEI_RST_LINK;
    end else if (wr_en && addr == `SMEI_OFS_LINKS) begin
      links_ff <= wdata[`SMEI_BIT_END_START];
    end
  end

  assign start_wr = wr_en && addr == `SMEI_OFS_TASK_START && wdata[`SMEI_BIT_TRIGGER];

  // start pulse, one cycle, from software or the link
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_task_ff <= 1'b0;
    end else begin
      start_task_ff <= start_wr || (end_hit && links_ff);
    end
  end

  // enables: set and clear are separate words, so zeros are harmless
  always_comb begin
    nxt_ien = ien_ff;
    if (wr_en && addr == `SMEI_OFS_IEN_SET) begin
      nxt_ien = ien_ff | wdata[`SMEI_EV_N-1:0];
    end else if (wr_en && addr == `SMEI_OFS_IEN_CLR) begin
      nxt_ien = ien_ff & ~wdata[`SMEI_EV_N-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ien_ff <= `SMEI_RST_EV;
    end else begin
      ien_ff <= nxt_ien;
    end
  end

  // sticky status, cleared by reading it; a new event beats the clear
  always_comb begin
    nxt_stat = stat_ff;
    if (rd_en && addr == `SMEI_OFS_IRQ_STAT) begin
      nxt_stat = '0;
    end
    nxt_stat = nxt_stat | ev_hit;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_ff <= `SMEI_RST_EV;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // flags keep irq up even after the status word was read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |((flags | stat_ff) & ien_ff);
    end
  end

  always_comb begin
    nxt_rdata = `SMEI_RST_WORD;
    if (rd_en) begin
      unique case (addr)
        `SMEI_OFS_EV_STOP:   nxt_rdata[0] = flags[`SMEI_BIT_STOP];
        `SMEI_OFS_EV_RXDONE: nxt_rdata[0] = flags[`SMEI_BIT_RXDONE];
        `SMEI_OFS_EV_END:    nxt_rdata[0] = flags[`SMEI_BIT_END];
        `SMEI_OFS_EV_TXDONE: nxt_rdata[0] = flags[`SMEI_BIT_TXDONE];
        `SMEI_OFS_EV_BEGAN:  nxt_rdata[0] = flags[`SMEI_BIT_BEGAN];
        `SMEI_OFS_LINKS:     nxt_rdata[`SMEI_BIT_END_START] = links_ff;
        `SMEI_OFS_IEN_SET:   nxt_rdata[`SMEI_EV_N-1:0] = ien_ff;
        `SMEI_OFS_IEN_CLR:   nxt_rdata[`SMEI_EV_N-1:0] = ien_ff;
        `SMEI_OFS_IRQ_STAT:  nxt_rdata[`SMEI_EV_N-1:0] = stat_ff;
        default:             nxt_rdata = `SMEI_RST_WORD;
      endcase
    end
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= `SMEI_RST_WORD;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // helper: completions seen since the last transfer began or ended
  logic rx_seen_h;
  logic tx_seen_h;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_seen_h <= 1'b0;
      tx_seen_h <= 1'b0;
    end else if (ev_started || end_hit) begin
      rx_seen_h <= 1'b0;
      tx_seen_h <= 1'b0;
    end else begin
      rx_seen_h <= rx_seen_h | ev_rx_done;
      tx_seen_h <= tx_seen_h | ev_tx_done;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_txdone_wr_free;
    ev_tx_done;
  endsequence

  property p_txflag;
    s_txdone_wr_free |=> flags[`SMEI_BIT_TXDONE];
  endproperty
  a_txflag: assert property (p_txflag) else $error("tx done not flagged");

  property p_txflag_read;
    (rd_en && addr == `SMEI_OFS_EV_TXDONE) |=> (rdata_ff == {31'h0000_0000, $past(flags[`SMEI_BIT_TXDONE])});
  endproperty
  a_txflag_read: assert property (p_txflag_read) else $error("tx done flag misread");

  property p_began_set;
    ev_started |=> flags[`SMEI_BIT_BEGAN] && xfer_ff == XF_BOTH;
  endproperty
  a_began_set: assert property (p_began_set) else $error("transfer began not flagged");

  property p_began_read;
    (rd_en && addr == `SMEI_OFS_EV_BEGAN) |=> (rdata_ff == {31'h0000_0000, $past(flags[`SMEI_BIT_BEGAN])});
  endproperty
  a_began_read: assert property (p_began_read) else $error("began flag misread");

  property p_link_on;
    // a second cause in the pulse cycle may legally extend it
    (end_hit && links_ff) |=> start_task_ff ##1 (!start_task_ff || $past(start_wr || (end_hit && links_ff)));
  endproperty
  a_link_on: assert property (p_link_on) else $error("link did not restart");

  property p_link_off;
    (end_hit && !links_ff && !start_wr) |=> !start_task_ff;
  endproperty
  a_link_off: assert property (p_link_off) else $error("start without link");

  property p_start_none;
    !(start_wr || (end_hit && links_ff)) |=> !start_task_ff;
  endproperty
  a_start_none: assert property (p_start_none) else $error("start with no cause");

  sequence s_links_wr;
    wr_en && addr == `SMEI_OFS_LINKS;
  endsequence

  property p_link_write;
    s_links_wr |=> (links_ff == $past(wdata[`SMEI_BIT_END_START]));
  endproperty
  a_link_write: assert property (p_link_write) else $error("link bit not written");

  property p_link_read;
    (rd_en && addr == `SMEI_OFS_LINKS) |=> (rdata_ff == {31'h0000_0000, $past(links_ff)});
  endproperty
  a_link_read: assert property (p_link_read) else $error("link bit misread");

  sequence s_ien_set_wr;
    wr_en && addr == `SMEI_OFS_IEN_SET;
  endsequence

  property p_ien_set;
    s_ien_set_wr |=> (ien_ff == ($past(ien_ff) | $past(wdata[4:0])));
  endproperty
  a_ien_set: assert property (p_ien_set) else $error("enable set wrong");

  property p_ien_read;
    (rd_en && (addr == `SMEI_OFS_IEN_SET || addr == `SMEI_OFS_IEN_CLR)) |=> (rdata_ff[4:0] == ien_ff)
      && (rdata_ff[31:5] == 27'h000_0000);
  endproperty
  a_ien_read: assert property (p_ien_read) else $error("enable readback wrong");

  property p_ien_clr;
    (wr_en && addr == `SMEI_OFS_IEN_CLR) |=> ((ien_ff & $past(wdata[4:0])) == 5'h00);
  endproperty
  a_ien_clr: assert property (p_ien_clr) else $error("enable clear failed");

  property p_ien_clr_keep;
    (wr_en && addr == `SMEI_OFS_IEN_CLR) |=> (ien_ff == ($past(ien_ff) & ~$past(wdata[4:0])));
  endproperty
  a_ien_clr_keep: assert property (p_ien_clr_keep) else $error("clear touched other enables");

  property p_ien_hold;
    !(wr_en && (addr == `SMEI_OFS_IEN_SET || addr == `SMEI_OFS_IEN_CLR)) |=> $stable(ien_ff);
  endproperty
  a_ien_hold: assert property (p_ien_hold) else $error("enable moved without write");

  property p_end_both;
    end_hit |-> (rx_seen_h || ev_rx_done) && (tx_seen_h || ev_tx_done);
  endproperty
  a_end_both: assert property (p_end_both) else $error("combined done too early");

  property p_end_rx_only;
    (ev_rx_done && !ev_tx_done && !tx_seen_h) |-> !end_hit;
  endproperty
  a_end_rx_only: assert property (p_end_rx_only) else $error("combined done on rx alone");

  property p_end_flag;
    end_hit |=> flags[`SMEI_BIT_END];
  endproperty
  a_end_flag: assert property (p_end_flag) else $error("combined done not flagged");

  property p_irq_up;
    (|(flags & ien_ff)) |=> irq_ff;
  endproperty
  a_irq_up: assert property (p_irq_up) else $error("irq missing");

  property p_irq_down;
    !(|((flags | stat_ff) & ien_ff)) |=> !irq_ff;
  endproperty
  a_irq_down: assert property (p_irq_down) else $error("irq without enabled event");

  property p_zero_set;
    (s_ien_set_wr and (wdata[4:0] == 5'h00)) |=> $stable(ien_ff);
  endproperty
  a_zero_set: assert property (p_zero_set) else $error("zero write changed enable");

endmodule // smei_regs

//--- smei_regs_bench.sv
// self-checking bench for the spi master event and interrupt register bank
`include "smei_defs.svh"

module smei_regs_bench
  import smei_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          clk;
  logic          rst;
  smei_addr_type addr;
  smei_word_type wdata;
  logic          wr_en;
  logic          rd_en;
  smei_word_type rdata;
  logic [3:0]    ev;
  logic          start_task;
  logic          irq;
  int            n_errors;
  int            tests_run;

  // ev bits: 0 stopped, 1 rx done, 2 tx done, 3 transfer began
  smei_regs smei_regs_i (
    .clk        (clk),
    .rst        (rst),
    .addr       (addr),
    .wdata      (wdata),
    .wr_en      (wr_en),
    .rd_en      (rd_en),
    .rdata      (rdata),
    .ev_stopped (ev[0]),
    .ev_rx_done (ev[1]),
    .ev_tx_done (ev[2]),
    .ev_started (ev[3]),
    .start_task (start_task),
    .irq        (irq)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic close_out;
    if (n_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input smei_word_type g, input smei_word_type e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input smei_addr_type a, input smei_word_type d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so look there
  task automatic rd_chk(input smei_addr_type a, input smei_word_type e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, e);
    @(posedge clk);
    #1;
    chk(rdata, `SMEI_RST_WORD);
  endtask

  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask

  // counts start pulses over a short window; catches doubles as well as misses
  task automatic starts(input smei_word_type e);
    smei_word_type n;
    n = '0;
    repeat (6) begin
      @(negedge clk);
      if (start_task === 1'b1) n++;
    end
    chk(n, e);
  endtask

  task automatic irq_chk(input logic e);
    repeat (3) @(posedge clk);
    #1;
    chk({31'h0, irq}, {31'h0, e});
  endtask

  task automatic t_reset;
    rd_chk(`SMEI_OFS_EV_TXDONE, `SMEI_RST_WORD);
    rd_chk(`SMEI_OFS_EV_BEGAN, `SMEI_RST_WORD);
    rd_chk(`SMEI_OFS_LINKS, `SMEI_RST_WORD);
    rd_chk(`SMEI_OFS_IEN_SET, `SMEI_RST_WORD);
    rd_chk(`SMEI_OFS_IEN_CLR, `SMEI_RST_WORD);
  endtask

  task automatic t_flags;
    pulse(2);
    rd_chk(`SMEI_OFS_EV_TXDONE, 32'h1);
    wr(`SMEI_OFS_EV_TXDONE, 32'h0);
    rd_chk(`SMEI_OFS_EV_TXDONE, 32'h0);
    pulse(3);
    rd_chk(`SMEI_OFS_EV_BEGAN, 32'h1);
    wr(`SMEI_OFS_EV_BEGAN, 32'h0);
    rd_chk(`SMEI_OFS_EV_BEGAN, 32'h0);
    irq_chk(1'b0);
    rd_chk(`SMEI_OFS_IRQ_STAT, 32'h18);
    wr(12'h7FC, 32'hFFFF_FFFF);
    rd_chk(12'h7FC, 32'h0);
  endtask

  task automatic t_enables;
    for (int i = 0; i < `SMEI_EV_N; i++) begin
      wr(`SMEI_OFS_IEN_SET, 32'h1 << i);
      rd_chk(`SMEI_OFS_IEN_SET, (32'h2 << i) - 32'h1);
    end
    wr(`SMEI_OFS_IEN_SET, 32'h0);
    rd_chk(`SMEI_OFS_IEN_SET, 32'h1F);
    wr(`SMEI_OFS_IEN_CLR, 32'h05);
    rd_chk(`SMEI_OFS_IEN_CLR, 32'h1A);
    rd_chk(`SMEI_OFS_IEN_SET, 32'h1A);
    wr(`SMEI_OFS_IEN_CLR, 32'h1F);
    rd_chk(`SMEI_OFS_IEN_SET, 32'h0);
  endtask

  // restart link: rx alone must not count, no link means no start
  task automatic t_link;
    wr(`SMEI_OFS_LINKS, 32'h1);
    rd_chk(`SMEI_OFS_LINKS, 32'h1);
    pulse(3);
    pulse(1);
    starts(32'h0);
    rd_chk(`SMEI_OFS_EV_END, 32'h0);
    pulse(2);
    starts(32'h1);
    rd_chk(`SMEI_OFS_EV_END, 32'h1);
    wr(`SMEI_OFS_EV_END, 32'h0);
    pulse(1);
    pulse(2);
    starts(32'h0);
    wr(`SMEI_OFS_LINKS, 32'h0);
    pulse(3);
    pulse(1);
    pulse(2);
    starts(32'h0);
    rd_chk(`SMEI_OFS_EV_END, 32'h1);
    rd_chk(`SMEI_OFS_EV_RXDONE, 32'h1);
    wr(`SMEI_OFS_TASK_START, 32'h1);
    starts(32'h1);
    rd_chk(`SMEI_OFS_IRQ_STAT, 32'h1E);
  endtask

  task automatic t_irq;
    wr(`SMEI_OFS_IEN_SET, 32'h08);
    pulse(2);
    irq_chk(1'b1);
    wr(`SMEI_OFS_EV_TXDONE, 32'h0);
    rd_chk(`SMEI_OFS_IRQ_STAT, 32'h08);
    irq_chk(1'b0);
    wr(`SMEI_OFS_IEN_CLR, 32'h08);
    pulse(2);
    irq_chk(1'b0);
    wr(`SMEI_OFS_IEN_SET, 32'h01);
    pulse(0);
    irq_chk(1'b1);
    rd_chk(`SMEI_OFS_EV_STOP, 32'h1);
    wr(`SMEI_OFS_EV_STOP, 32'h0);
    wr(`SMEI_OFS_EV_TXDONE, 32'h0);
    rd_chk(`SMEI_OFS_IRQ_STAT, 32'h09);
    irq_chk(1'b0);
  endtask

  // hang guard, generous against the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    close_out();
  end

  initial begin
    n_errors  = 0;
    tests_run = 0;
    rst       = 1'b1;
    addr      = '0;
    wdata     = '0;
    wr_en     = 1'b0;
    rd_en     = 1'b0;
    ev        = 4'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_flags();
    t_enables();
    t_link();
    t_irq();
    close_out();
  end
endmodule // smei_regs_bench
